// >>> verilog/disp_port_cfg.svh
// Constants for the I2C display RAM port: address, commands, RAM geometry.
`ifndef DISP_PORT_CFG_SVH
`define DISP_PORT_CFG_SVH
`define SLAVE_ADDR_HI 6'h1e
`define RAM_COLS 11'd132
`define LAST_COL 8'h83
`define RAM_WORDS 1056
`define LINE_COUNT 7'd64
`define CMD_COL_LO 4'h0
`define CMD_COL_HI 4'h1
`define CMD_START_TOP 2'h1
`define CMD_PAGE_TOP 5'h16
`define CMD_SEG_NORMAL 8'ha0
`define CMD_SEG_FLIP 8'ha1
`define CMD_COM_NORMAL 8'hc0
`define CMD_COM_REV 8'hc8
`define REG_CTRL 4'h0
`define REG_COLUMN 4'h1
`define REG_START 4'h2
`define REG_PAGE 4'h3
`define CTRL_SEG_BIT 0
`define CTRL_COM_BIT 1
`define CTRL_FOLLOWS_BIT 7
`define CTRL_RAM_BIT 6
`define STATUS_RESET 8'h00
`endif

// >>> verilog/disp_port_pkg.sv
// Types shared by the I2C display RAM port.
package disp_port_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [2:0] {
      st_idle,
      st_rx,
      st_rx_ack,
      st_tx,
      st_tx_ack,
      st_ignore
   } i2c_state_t;
endpackage

// >>> verilog/i2c_display_ram_port.sv
// I2C slave port with parallel write path, command decoder and 132x64 display RAM.
// Structure, from the pins inward.
// Every pin from outside the clock domain passes two flip-flops before logic reads it.
// The link clock and data get a third stage so edges and bus conditions come from settled values.
// The sequencer walks address, acknowledge, receive and transmit phases on the synchronised edges.
// A byte is only handed on at the fall that closes its eighth bit, never while the clock is high.
// Control bytes are tracked apart from data bytes, so that the header flag decides what comes next.
// The parallel front end and the link merge into one byte stream with one destination flag.
// A RAM byte lands at the current page and column, and the column then moves on by one.
// A command byte updates column halves, page, start line or the two mapping flips.
// Software reaches the flips through the register port and may read back the pointers.
// Scan-out is purely combinational up to one output flop, so a new start line shows at once.
// Limitations worth knowing.
// The column counter sticks at its last value, so repeated writes there overwrite one byte.
// A column set past the last one by command drops RAM writes until it is set again.
// The page never moves by itself; software must set both page and column for the next page.
// Bytes after a missing acknowledge or a foreign address are ignored until the next START.
// The block never stretches the link clock, so it relies on sampling well inside each phase.
`include "disp_port_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module i2c_display_ram_port (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic address_select_pin_in,
   input wire logic ram_or_instr_pin_in,
   input wire logic par_wr_in,
   input wire disp_port_pkg::byte_t par_data_in,
   input wire logic [3:0] reg_addr_in,
   input wire disp_port_pkg::byte_t reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output disp_port_pkg::byte_t reg_rdata_out,
   input wire logic [5:0] row_index_in,
   input wire logic [7:0] seg_index_in,
   output logic pixel_out
);
   import disp_port_pkg::*;

   // Flat RAM index of a page and column.
   function automatic logic [10:0] ram_index(input logic [2:0] page, input logic [7:0] col);
      ram_index = 11'(page * `RAM_COLS) + {3'b000, col};
   endfunction

   byte_t mem [0:`RAM_WORDS-1];
   logic [2:0] scl_q;
   logic [2:0] sda_q;
   logic [2:0] wr_q;
   byte_t pdat_s1_q;
   byte_t pdat_q;
   logic [1:0] pa0_q;
   logic [1:0] asel_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   i2c_state_t state_q;
   logic [3:0] bit_cnt_q;
   byte_t rx_sh_q;
   byte_t tx_sh_q;
   logic addr_phase_q;
   logic read_q;
   logic expect_ctrl_q;
   logic follows_q;
   logic ram_sel_q;
   logic ack_ok_q;
   logic i2c_byte;
   logic i2c_tx_load;
   logic par_byte;
   logic byte_vld;
   byte_t byte_dat;
   logic byte_ram;
   logic [7:0] col_q;
   logic [2:0] page_q;
   logic [5:0] start_q;
   logic seg_flip_q;
   logic com_rev_q;
   byte_t status;
   byte_t tx_byte;
   logic [5:0] row_eff;
   logic [5:0] line;
   logic [7:0] col_eff;
   byte_t pix_word;

   // Two-stage synchronisers plus a history stage for edge detection.
   // The link lines reset to their idle high level, so no false edge follows reset.
   // The address strap is synchronised as well, although it is normally static.
   // Only the second and third stages of each synchroniser are read by logic.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
         wr_q <= 3'h0;
         pdat_s1_q <= 8'h00;
         pdat_q <= 8'h00;
         pa0_q <= 2'h0;
         asel_q <= 2'h0;
      end else begin
         scl_q <= {scl_q[1:0], scl_in};
         sda_q <= {sda_q[1:0], sda_in};
         wr_q <= {wr_q[1:0], par_wr_in};
         pdat_s1_q <= par_data_in;
         pdat_q <= pdat_s1_q;
         pa0_q <= {pa0_q[0], ram_or_instr_pin_in};
         asel_q <= {asel_q[0], address_select_pin_in};
      end
   end

   // Edges and bus conditions, seen only from the second and third stages.
   // A data change is a bus condition only while both clock stages read high.
   // Data moved by the master while the clock is low therefore never looks like START or STOP.
   // Both lines pass equal stages, so their relative timing is kept.
   assign scl_rise = scl_q[1] & ~scl_q[2];
   assign scl_fall = ~scl_q[1] & scl_q[2];
   assign start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
   assign stop_det = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

   // Status byte offered on a read with the RAM flag cleared.
   assign status = `STATUS_RESET | (8'(seg_flip_q) << `CTRL_SEG_BIT) | (8'(com_rev_q) << `CTRL_COM_BIT);
   assign tx_byte = ram_sel_q ? mem[ram_index(page_q, col_q)] : status;

   // A write byte is complete at the falling edge after its eighth bit.
   assign i2c_byte = (state_q == st_rx) && scl_fall && (bit_cnt_q == 4'd8) && !addr_phase_q;
   // A read byte is loaded at the fall that closes an acknowledge.
   // With the RAM flag set, the column moves on at that same load, so the next byte is fetched from the next column.
   // A missing master acknowledge loads nothing and leaves the column alone.
   assign i2c_tx_load = scl_fall && ((state_q == st_rx_ack && read_q) || (state_q == st_tx_ack && ack_ok_q));

   // I2C slave sequencer.
   // Idle waits for START; receive shifts eight bits in on clock rises.
   // The receive acknowledge pulls the data line from one fall to the next.
   // Transmit changes the data line only after a clock fall, one bit per low phase.
   // The transmit acknowledge samples the master's answer on the clock rise.
   // Ignore keeps the line released until the next START, after a foreign address or a refusal.
   // START and STOP override every state, so a cut frame never leaves the line pulled.
   // The pull is a registered level, so it cannot glitch while the clock is high.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q <= st_idle;
         bit_cnt_q <= 4'h0;
         rx_sh_q <= 8'h00;
         tx_sh_q <= 8'h00;
         addr_phase_q <= 1'b0;
         read_q <= 1'b0;
         ack_ok_q <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (start_det) begin
         state_q <= st_rx;
         bit_cnt_q <= 4'h0;
         addr_phase_q <= 1'b1;
         read_q <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (stop_det) begin
         state_q <= st_idle;
         sda_oe_out <= 1'b0;
      end else begin
         case (state_q)
            st_rx: begin
               if (scl_rise && bit_cnt_q != 4'd8) begin
                  rx_sh_q <= {rx_sh_q[6:0], sda_q[2]};
                  bit_cnt_q <= bit_cnt_q + 4'd1;
               end else if (scl_fall && bit_cnt_q == 4'd8) begin
                  if (addr_phase_q && rx_sh_q[7:1] != {`SLAVE_ADDR_HI, asel_q[1]}) begin
                     state_q <= st_ignore;
                  end else begin
                     if (addr_phase_q) begin
                        read_q <= rx_sh_q[0];
                     end
                     addr_phase_q <= 1'b0;
                     state_q <= st_rx_ack;
                     sda_oe_out <= 1'b1;
                  end
               end
            end
            st_rx_ack: begin
               if (scl_fall) begin
                  bit_cnt_q <= 4'h0;
                  if (read_q) begin
                     tx_sh_q <= tx_byte;
                     sda_oe_out <= ~tx_byte[7];
                     state_q <= st_tx;
                  end else begin
                     sda_oe_out <= 1'b0;
                     state_q <= st_rx;
                  end
               end
            end
            st_tx: begin
               if (scl_fall) begin
                  if (bit_cnt_q == 4'd7) begin
                     sda_oe_out <= 1'b0;
                     state_q <= st_tx_ack;
                  end else begin
                     tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                     sda_oe_out <= ~tx_sh_q[6];
                     bit_cnt_q <= bit_cnt_q + 4'd1;
                  end
               end
            end
            st_tx_ack: begin
               if (scl_rise) begin
                  ack_ok_q <= ~sda_q[2];
               end else if (scl_fall) begin
                  bit_cnt_q <= 4'h0;
                  if (ack_ok_q) begin
                     tx_sh_q <= tx_byte;
                     sda_oe_out <= ~tx_byte[7];
                     state_q <= st_tx;
                  end else begin
                     state_q <= st_ignore;
                  end
               end
            end
            st_ignore: begin
               sda_oe_out <= 1'b0;
            end
            default: begin
               state_q <= st_idle;
               sda_oe_out <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain: only a low level is ever driven.
   // The high level comes from the bus pull-up whenever the enable is low.
   // This keeps the block from ever fighting another driver on the line.
   assign sda_out = 1'b0;

   // Control byte tracking for write transfers.
   // Every START expects a control byte first, whatever the last frame left behind.
   // With the header flag set, control and data bytes alternate.
   // With it cleared, every byte to STOP is data of the same destination.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         expect_ctrl_q <= 1'b1;
         follows_q <= 1'b0;
         ram_sel_q <= 1'b0;
      end else if (start_det) begin
         expect_ctrl_q <= 1'b1;
      end else if (i2c_byte && !read_q) begin
         if (expect_ctrl_q) begin
            follows_q <= rx_sh_q[`CTRL_FOLLOWS_BIT];
            ram_sel_q <= rx_sh_q[`CTRL_RAM_BIT];
            expect_ctrl_q <= 1'b0;
         end else begin
            expect_ctrl_q <= follows_q;
         end
      end
   end

   // One byte stream from either front end toward RAM or the decoder.
   assign par_byte = wr_q[1] & ~wr_q[2];
   assign byte_vld = (i2c_byte && !read_q && !expect_ctrl_q) || par_byte;
   assign byte_dat = par_byte ? pdat_q : rx_sh_q;
   assign byte_ram = par_byte ? pa0_q[1] : ram_sel_q;

   // Display RAM write port.
   // The storage has no reset, so its content is unknown until written.
   // Writes at a column beyond the last are dropped to keep the index in range.
   // The last column itself is still written, so a long stream overwrites it.
   always_ff @(posedge clk_in) begin
      if (byte_vld && byte_ram && col_q <= `LAST_COL) begin
         mem[ram_index(page_q, col_q)] <= byte_dat;
      end
   end

   // Column, page and start line registers, command decoder and software writes.
   // A software write to the control register wins over a data byte in the same cycle.
   // A RAM access wins over command decoding, since one byte is never both.
   // The column increments on every RAM write and every RAM read load while it is below the last column.
   // The page only changes by its command, never on its own.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         col_q <= 8'h00;
         page_q <= 3'h0;
         start_q <= 6'h00;
         seg_flip_q <= 1'b0;
         com_rev_q <= 1'b0;
      end else if (reg_wr_in && reg_addr_in == `REG_CTRL) begin
         seg_flip_q <= reg_wdata_in[`CTRL_SEG_BIT];
         com_rev_q <= reg_wdata_in[`CTRL_COM_BIT];
      end else if ((byte_vld && byte_ram) || (i2c_tx_load && ram_sel_q)) begin
         if (col_q < `LAST_COL) begin
            col_q <= col_q + 8'h01;
         end
      end else if (byte_vld) begin
         if (byte_dat[7:4] == `CMD_COL_LO) begin
            col_q <= {col_q[7:4], byte_dat[3:0]};
         end else if (byte_dat[7:4] == `CMD_COL_HI) begin
            col_q <= {byte_dat[3:0], col_q[3:0]};
         end else if (byte_dat[7:6] == `CMD_START_TOP) begin
            start_q <= byte_dat[5:0];
         end else if (byte_dat[7:3] == `CMD_PAGE_TOP) begin
            page_q <= byte_dat[2:0];
         end else if (byte_dat == `CMD_SEG_NORMAL || byte_dat == `CMD_SEG_FLIP) begin
            seg_flip_q <= byte_dat[0];
         end else if (byte_dat == `CMD_COM_NORMAL || byte_dat == `CMD_COM_REV) begin
            com_rev_q <= byte_dat[3];
         end
      end
   end

   // Register read port, data one cycle after the strobe.
   // Outside that cycle the data read back as zero, so a stale value is never seen.
   // Offsets beyond the map read as zero as well.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `REG_CTRL: reg_rdata_out <= status;
            `REG_COLUMN: reg_rdata_out <= col_q;
            `REG_START: reg_rdata_out <= {2'b00, start_q};
            `REG_PAGE: reg_rdata_out <= {5'b00000, page_q};
            default: reg_rdata_out <= 8'h00;
         endcase
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   // Scan-out mapping: row reversal, start line offset and segment flip.
   // The sum of start line and row wraps in six bits, which is the modulo over all lines.
   // Row reversal is applied before the offset, so with rows reversed the start line shows on row 63.
   // A segment index beyond the last column reads a byte of the next page, or an undefined one on page 7.
   assign row_eff = com_rev_q ? 6'd63 - row_index_in : row_index_in;
   assign line = start_q + row_eff;
   assign col_eff = seg_flip_q ? `LAST_COL - seg_index_in : seg_index_in;
   assign pix_word = mem[ram_index(line[5:3], col_eff)];

   // Pixel output follows the live start line, so scrolling needs no RAM rewrite.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pixel_out <= 1'b0;
      end else begin
         pixel_out <= pix_word[line[2:0]];
      end
   end
endmodule
`default_nettype wire

// >>> test/i2c_display_ram_port_asserts.sv
// Port checker for the I2C display RAM port.
`timescale 1ns/1ps
`default_nettype none
module i2c_display_ram_port_asserts (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic [3:0] reg_addr_in,
   input wire logic reg_rd_in,
   input wire disp_port_pkg::byte_t reg_rdata_out,
   input wire logic pixel_out
);
   import disp_port_pkg::*;
   // All checks run on the system clock and rest during reset.
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   chk_open_drain: assert property (sda_out == 1'b0) else $error("data pin driven high");
   chk_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in) else $error("pull moved in clock high");
   chk_oe_hold_high: assert property ($rose(scl_in) |=> $stable(sda_oe_out) [*6])
      else $error("pull not steady in clock high");
   chk_pull_span: assert property ($rose(sda_oe_out) |-> sda_oe_out [*8]) else $error("pull too short");
   chk_flag_bits: assert property (reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out[7:2] == 6'h00)
      else $error("control reads spare bits");
   chk_col_limit: assert property (reg_rd_in && reg_addr_in == 4'h1 |=> reg_rdata_out <= 8'h83)
      else $error("column past last");
   chk_start_range: assert property (reg_rd_in && reg_addr_in == 4'h2 |=> reg_rdata_out < 8'h40)
      else $error("start line out of range");
   chk_page_range: assert property (reg_rd_in && reg_addr_in == 4'h3 |=> reg_rdata_out < 8'h08)
      else $error("page out of range");
   chk_reset_quiet: assert property ($rose(rst_b_in) |-> !sda_oe_out && !pixel_out && reg_rdata_out == 8'h00)
      else $error("outputs active after reset");
endmodule
bind i2c_display_ram_port i2c_display_ram_port_asserts chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
   .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .reg_addr_in(reg_addr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pixel_out(pixel_out));
`default_nettype wire

// >>> test/i2c_master_model.sv
// Behavioural I2C bus master driving the link clock and its side of the data line.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   output logic scl_out,
   output logic sda_drv_out,
   input wire logic sda_in
);
   import disp_port_pkg::*;
   localparam realtime Q = 31.25;
   // Clock rests high and data is released between frames.
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   // One bit: data moves only in clock low and is sampled mid-high.
   task automatic bit_x(input logic b, output logic r);
      #Q sda_drv_out = b;
      #Q scl_out = 1'b1;
      #Q r = sda_in;
      #Q scl_out = 1'b0;
   endtask
   // Data falls while the clock is high.
   task automatic start();
      #Q sda_drv_out = 1'b1;
      #Q scl_out = 1'b1;
      #Q sda_drv_out = 1'b0;
      #Q scl_out = 1'b0;
   endtask
   // Data rises while the clock is high, closing the frame.
   task automatic stop();
      #Q sda_drv_out = 1'b0;
      #Q scl_out = 1'b1;
      #Q sda_drv_out = 1'b1;
      #Q;
   endtask
   // Eight bits, most significant first, then a ninth clock for the answer.
   task automatic wbyte(input byte_t d, output logic nk);
      for (int i = 7; i >= 0; i--) bit_x(d[i], nk);
      bit_x(1'b1, nk);
   endtask
   task automatic rbyte(input logic nk, output byte_t d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(nk, r);
   endtask
endmodule
`default_nettype wire

// >>> test/i2c_display_ram_port_bench.sv
// Self-checking bench for the I2C display RAM port.
`timescale 1ns/1ps
`default_nettype none
module i2c_display_ram_port_bench;
   import disp_port_pkg::*;
   logic clk, rst_b = 1'b0, scl, sda_m, asel = 1'b0, rip = 1'b0, pwr = 1'b0;
   logic rwr = 1'b0, rrd = 1'b0, sdo, oe, pix, nk;
   logic [3:0] ra = 4'h0;
   logic [5:0] row = 6'h00;
   byte_t pd = 8'h00, rwd = 8'h00, seg = 8'h00, rdat, d;
   wire logic sda = sda_m & ~oe;
   int n_mismatch = 0;
   int total_checks = 0;
   byte_t q[$];
   // Rows: command byte, register offset, expected register value.
   logic [19:0] tbl [11] = '{20'h05105, 20'h13135, 20'h7f23f, 20'h4a20a, 20'h40200, 20'hb7307,
      20'hb1301, 20'ha1001, 20'hc8003, 20'hc0001, 20'ha0000};
   i2c_master_model m (.scl_out(scl), .sda_drv_out(sda_m), .sda_in(sda));
   i2c_display_ram_port dut (.clk_in(clk), .rst_b_in(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sdo),
      .sda_oe_out(oe), .address_select_pin_in(asel), .ram_or_instr_pin_in(rip), .par_wr_in(pwr),
      .par_data_in(pd), .reg_addr_in(ra), .reg_wdata_in(rwd), .reg_wr_in(rwr), .reg_rd_in(rrd),
      .reg_rdata_out(rdat), .row_index_in(row), .seg_index_in(seg), .pixel_out(pix));
   // System clock, 8 ns period.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task rdc(input logic [3:0] a, input byte_t e);
      @(posedge clk);
      rrd <= 1'b1;
      ra <= a;
      @(posedge clk);
      rrd <= 1'b0;
      #1 chk("register", rdat, e);
   endtask
   task wr(input logic [3:0] a, input byte_t v);
      @(posedge clk);
      rwr <= 1'b1;
      ra <= a;
      rwd <= v;
      @(posedge clk);
      rwr <= 1'b0;
   endtask
   // Write frame of the queued bytes, every byte answered alike.
   task send(input logic ack);
      m.start();
      foreach (q[i]) begin
         m.wbyte(q[i], nk);
         chk("ack", {7'h00, nk}, {7'h00, ~ack});
      end
      m.stop();
      q.delete();
   endtask
   task pc(input logic [5:0] r, input byte_t s, input logic e);
      @(posedge clk);
      row <= r;
      seg <= s;
      repeat (3) @(posedge clk);
      #1 chk("pixel", {7'h00, pix}, {7'h00, e});
   endtask
   task par(input logic p, input byte_t v);
      @(posedge clk);
      rip <= p;
      pd <= v;
      repeat (5) @(posedge clk);
      pwr <= 1'b1;
      repeat (6) @(posedge clk);
      pwr <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Main sequence: table of commands, then the awkward cases.
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rdc(4'h1, 8'h00);
      rdc(4'h2, 8'h00);
      foreach (tbl[i]) begin
         q = '{8'h78, 8'h00, tbl[i][19:12]};
         send(1'b1);
         rdc(tbl[i][11:8], tbl[i][7:0]);
      end
      asel <= 1'b1;
      q = '{8'h78, 8'h00, 8'hb5};
      send(1'b0);
      rdc(4'h3, 8'h01);
      q = '{8'h7a, 8'h80, 8'h02, 8'h80, 8'h18, 8'h40, 8'ha5, 8'h77, 8'h3c};
      send(1'b1);
      rdc(4'h1, 8'h83);
      q = '{8'h7a, 8'h80, 8'h02, 8'h40};
      send(1'b1);
      m.start();
      m.wbyte(8'h7b, nk);
      chk("ack", {7'h00, nk}, 8'h00);
      m.rbyte(1'b0, d);
      chk("rdata", d, 8'ha5);
      m.rbyte(1'b1, d);
      chk("rdata", d, 8'h3c);
      m.rbyte(1'b1, d);
      chk("released", d, 8'hff);
      m.stop();
      rdc(4'h1, 8'h83);
      pc(6'd8, 8'h82, 1'b1);
      pc(6'd9, 8'h82, 1'b0);
      wr(4'h0, 8'h01);
      pc(6'd10, 8'h01, 1'b1);
      wr(4'h0, 8'h02);
      pc(6'd55, 8'h82, 1'b1);
      wr(4'h0, 8'h00);
      q = '{8'h7a, 8'h00, 8'h7c};
      send(1'b1);
      pc(6'd12, 8'h82, 1'b1);
      wr(4'h1, 8'h55);
      rdc(4'h1, 8'h83);
      rdc(4'hf, 8'h00);
      par(1'b0, 8'hb4);
      rdc(4'h3, 8'h04);
      par(1'b0, 8'h10);
      par(1'b0, 8'h00);
      par(1'b1, 8'h0f);
      rdc(4'h1, 8'h01);
      // A second reset in mid-run must clear column, start line and flips again.
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rdc(4'h1, 8'h00);
      rdc(4'h2, 8'h00);
      rdc(4'h0, 8'h00);
      close_out();
   end
   // Cuts a hung run short.
   initial begin
      #300us;
      n_mismatch++;
      close_out();
   end
endmodule
`default_nettype wire
